// >>> src/hlf_pkg.sv
package hlf_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_LATCHED = 8'h08;
    localparam logic [7:0] OFF_ERR = 8'h0c;
    localparam logic [7:0] OFF_SUB = 8'h10;
    localparam logic [7:0] OFF_IRQ_ST = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    // Control and command register fields and reset values.
    localparam int CTRL_POS_EN = 0;
    localparam int CTRL_NEG_EN = 1;
    localparam int CTRL_DCLS_LSB = 4;
    localparam logic [3:0] DCLS_RST = 4'h1;
    localparam int CMD_FRST = 0;
    // Latched signal word bits.
    localparam int LW_SWLIM = 2;
    localparam int LW_HOME = 10;
    localparam int LW_DEV = 22;
    // Interrupt status bits.
    localparam int IRQ_SWLIM = 0;
    localparam int IRQ_DEV = 1;
    localparam int IRQ_HOME = 2;
    // Switch vector positions.
    localparam int SW_REF = 0;
    localparam int SW_NEG = 1;
    localparam int SW_POS = 2;
    // Error codes and classes.
    localparam logic [15:0] E_SWL_POS = 16'ha31e;
    localparam logic [15:0] E_SWL_NEG = 16'ha31f;
    localparam logic [15:0] E_DEV = 16'ha320;
    localparam logic [15:0] E_HOME = 16'ha324;
    localparam logic [15:0] E_LIM_OFF = 16'ha325;
    localparam logic [15:0] E_NO_REF = 16'ha326;
    localparam logic [15:0] E_TRAVEL_LIM = 16'ha327;
    localparam logic [15:0] E_ALREADY = 16'ha328;
    localparam logic [15:0] E_MULTI = 16'ha329;
    localparam logic [15:0] E_POS_OPP = 16'ha32a;
    localparam logic [15:0] E_NEG_OPP = 16'ha32b;
    localparam logic [15:0] E_REF_GL = 16'ha32c;
    localparam logic [15:0] E_POS_GL = 16'ha32d;
    localparam logic [15:0] E_NEG_GL = 16'ha32e;
    localparam logic [3:0] CLS_1 = 4'h1;
    // Least time a switch must stay active to count as a real edge.
    localparam int CLK_NS = 40;
    localparam int MIN_ON_NS = 1000;
    localparam logic [7:0] MIN_ON_CYC =
        8'((MIN_ON_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        HM_POS_LIM,
        HM_NEG_LIM,
        HM_REF_REV,
        HM_REF_NOREV
    } hlf_hmode_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic refs;
    } hlf_sw_t;

    typedef struct packed {
        logic [15:0] code;
        logic [3:0] cls;
    } hlf_err_t;
endpackage : hlf_pkg

// >>> src/hlf_top.sv
// Our own choices: the AXI4-Lite slave port and the register offsets.
module hlf_top
    import hlf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire hlf_sw_t sw_pins,
    input wire logic sw_lim_pos,
    input wire logic sw_lim_neg,
    input wire logic pos_dev_exceeded,
    input wire logic cmd_req,
    input wire logic homing_start,
    input wire hlf_hmode_t homing_mode,
    input wire logic homing_dir_pos,
    input wire logic homing_active,
    output logic cmd_reject,
    output logic motion_stop,
    output logic err_valid,
    output hlf_err_t err_report,
    output logic irq
);

    typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_HALT} hlf_hstate_t;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    function automatic logic is_sub(input logic [15:0] c);
        return (c >= E_LIM_OFF) && (c <= E_MULTI);
    endfunction : is_sub

    logic [7:0] aw_addr_reg;
    logic aw_got_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_got_reg;
    logic do_wr;
    logic [31:0] wmask;
    logic frst;
    logic pos_en_reg;
    logic neg_en_reg;
    logic [3:0] dcls_reg;
    logic [31:0] lw_reg;
    logic [31:0] lw_set;
    logic [15:0] sub_reg;
    logic [2:0] irq_st_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_ev;
    logic [2:0] sw_meta;
    logic [2:0] sw_sync;
    logic [2:0] sw_prev;
    logic [2:0] rise;
    logic [2:0] short_on;
    logic [7:0] on_cnt [3];
    logic [2:0] seen_reg;
    logic multi;
    hlf_hstate_t hs_reg;
    hlf_hmode_t mode_reg;
    logic hm_hit;
    logic [15:0] hm_code;
    logic swlp_prev;
    logic swln_prev;
    logic dev_prev;
    logic swl_pos_ev;
    logic swl_neg_ev;
    logic dev_ev;
    logic [31:0] rd_val;
    logic rd_ok;

    // Switch pins come from the field and are synchronised first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_meta <= 3'h0;
            sw_sync <= 3'h0;
            sw_prev <= 3'h0;
        end else begin
            sw_meta <= sw_pins;
            sw_sync <= sw_meta;
            sw_prev <= sw_sync;
        end
    end

    assign rise = sw_sync & ~sw_prev;
    assign multi = (sw_sync[SW_POS] & sw_sync[SW_NEG]) |
                   (sw_sync[SW_POS] & sw_sync[SW_REF]) |
                   (sw_sync[SW_NEG] & sw_sync[SW_REF]);

    // Counts how long each switch has been active, saturating.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                on_cnt[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!sw_sync[i]) begin
                    on_cnt[i] <= 8'h00;
                end else if (on_cnt[i] != MIN_ON_CYC) begin
                    on_cnt[i] <= on_cnt[i] + 8'h01;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            short_on[i] = sw_prev[i] & ~sw_sync[i] &
                          (on_cnt[i] < MIN_ON_CYC);
        end
    end

    // Homing checks, in falling priority.
    always_comb begin
        hm_hit = 1'b0;
        hm_code = 16'h0000;
        if (hs_reg == HS_IDLE && homing_start) begin
            hm_hit = 1'b1;
            if (multi) begin
                hm_code = E_MULTI;
            end else if ((homing_mode == HM_POS_LIM && !pos_en_reg) ||
                         (homing_mode == HM_NEG_LIM && !neg_en_reg)) begin
                hm_code = E_LIM_OFF;
            end else if (homing_mode == HM_REF_NOREV && |sw_sync) begin
                hm_code = E_ALREADY;
            end else begin
                hm_hit = 1'b0;
            end
        end else if (hs_reg == HS_RUN) begin
            hm_hit = 1'b1;
            if (multi) begin
                hm_code = E_MULTI;
            end else if (mode_reg == HM_REF_NOREV &&
                         (homing_dir_pos ? rise[SW_POS] : rise[SW_NEG])) begin
                hm_code = E_TRAVEL_LIM;
            end else if (!homing_dir_pos && rise[SW_POS]) begin
                hm_code = E_POS_OPP;
            end else if (homing_dir_pos && rise[SW_NEG]) begin
                hm_code = E_NEG_OPP;
            end else if (mode_reg == HM_REF_REV && seen_reg[SW_POS] &&
                         seen_reg[SW_NEG] && !seen_reg[SW_REF]) begin
                hm_code = E_NO_REF;
            end else if (short_on[SW_REF]) begin
                hm_code = E_REF_GL;
            end else if (short_on[SW_POS]) begin
                hm_code = E_POS_GL;
            end else if (short_on[SW_NEG]) begin
                hm_code = E_NEG_GL;
            end else begin
                hm_hit = 1'b0;
            end
        end
    end

    // A halted homing run waits for a fault reset before it may restart.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_reg <= HS_IDLE;
            mode_reg <= HM_POS_LIM;
        end else begin
            case (hs_reg)
                HS_IDLE: begin
                    if (homing_start) begin
                        mode_reg <= homing_mode;
                        hs_reg <= hm_hit ? HS_HALT : HS_RUN;
                    end
                end
                HS_RUN: begin
                    if (hm_hit) begin
                        hs_reg <= HS_HALT;
                    end else if (!homing_active) begin
                        hs_reg <= HS_IDLE;
                    end
                end
                HS_HALT: begin
                    if (frst) begin
                        hs_reg <= HS_IDLE;
                    end
                end
                default: hs_reg <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= 3'h0;
        end else if (hs_reg != HS_RUN) begin
            seen_reg <= 3'h0;
        end else begin
            seen_reg <= seen_reg | sw_sync;
        end
    end

    // Software limits and deviation come from on-chip motion logic.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swlp_prev <= 1'b0;
            swln_prev <= 1'b0;
            dev_prev <= 1'b0;
        end else begin
            swlp_prev <= sw_lim_pos;
            swln_prev <= sw_lim_neg;
            dev_prev <= pos_dev_exceeded;
        end
    end

    assign swl_pos_ev = sw_lim_pos & (cmd_req | ~swlp_prev);
    assign swl_neg_ev = sw_lim_neg & (cmd_req | ~swln_prev);
    assign dev_ev = pos_dev_exceeded & ~dev_prev;

    always_comb begin
        lw_set = 32'h0000_0000;
        lw_set[LW_SWLIM] = swl_pos_ev | swl_neg_ev;
        lw_set[LW_DEV] = dev_ev;
        lw_set[LW_HOME] = hm_hit;
    end

    assign irq_ev = {hm_hit, dev_ev, swl_pos_ev | swl_neg_ev};

    // The newest code stays until another event replaces it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_report <= '0;
            err_valid <= 1'b0;
            sub_reg <= 16'h0000;
        end else begin
            err_valid <= hm_hit | swl_pos_ev | swl_neg_ev | dev_ev;
            if (hm_hit) begin
                if (is_sub(hm_code)) begin
                    err_report <= '{E_HOME, CLS_1};
                    sub_reg <= hm_code;
                end else begin
                    err_report <= '{hm_code, CLS_1};
                end
            end else if (swl_pos_ev) begin
                err_report <= '{E_SWL_POS, CLS_1};
            end else if (swl_neg_ev) begin
                err_report <= '{E_SWL_NEG, CLS_1};
            end else if (dev_ev) begin
                err_report <= '{E_DEV, dcls_reg};
            end
        end
    end

    // A new event in the clearing cycle wins over the fault reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lw_reg <= 32'h0000_0000;
            motion_stop <= 1'b0;
        end else begin
            lw_reg <= (frst ? 32'h0000_0000 : lw_reg) | lw_set;
            motion_stop <= (motion_stop & ~frst) | (|lw_set);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reject <= 1'b0;
        end else begin
            cmd_reject <= cmd_req & (sw_lim_pos | sw_lim_neg);
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b0;
            aw_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (awready && awvalid) begin
            awready <= 1'b0;
            aw_got_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (do_wr) begin
            aw_got_reg <= 1'b0;
        end else if (!aw_got_reg && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wready <= 1'b0;
            w_got_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (wready && wvalid) begin
            wready <= 1'b0;
            w_got_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (do_wr) begin
            w_got_reg <= 1'b0;
        end else if (!w_got_reg && !bvalid) begin
            wready <= 1'b1;
        end
    end

    assign do_wr = aw_got_reg & w_got_reg & ~bvalid;
    assign wmask = w_data_reg & strb_mask(w_strb_reg);
    assign frst = do_wr && aw_addr_reg == OFF_CMD && wmask[CMD_FRST];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            case (aw_addr_reg)
                OFF_CTRL, OFF_CMD, OFF_IRQ_ST, OFF_IRQ_MASK,
                OFF_LATCHED, OFF_ERR, OFF_SUB: bresp <= RESP_OKAY;
                default: bresp <= RESP_DECERR;
            endcase
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Limit enables steer the homing checks; class feeds deviation code.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_en_reg <= 1'b1;
            neg_en_reg <= 1'b1;
            dcls_reg <= DCLS_RST;
            irq_mask_reg <= 3'h0;
        end else if (do_wr && w_strb_reg[0]) begin
            if (aw_addr_reg == OFF_CTRL) begin
                pos_en_reg <= w_data_reg[CTRL_POS_EN];
                neg_en_reg <= w_data_reg[CTRL_NEG_EN];
                dcls_reg <= w_data_reg[CTRL_DCLS_LSB +: 4];
            end else if (aw_addr_reg == OFF_IRQ_MASK) begin
                irq_mask_reg <= w_data_reg[2:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_st_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (do_wr && aw_addr_reg == OFF_IRQ_ST) begin
                irq_st_reg <= (irq_st_reg & ~wmask[2:0]) | irq_ev;
            end else begin
                irq_st_reg <= irq_st_reg | irq_ev;
            end
            irq <= |(irq_st_reg & irq_mask_reg);
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (araddr)
            OFF_CTRL: begin
                rd_val[CTRL_POS_EN] = pos_en_reg;
                rd_val[CTRL_NEG_EN] = neg_en_reg;
                rd_val[CTRL_DCLS_LSB +: 4] = dcls_reg;
            end
            OFF_CMD: rd_val = 32'h0000_0000;
            OFF_LATCHED: rd_val = lw_reg;
            OFF_ERR: rd_val = {12'h000, err_report};
            OFF_SUB: rd_val = {16'h0000, sub_reg};
            OFF_IRQ_ST: rd_val = {29'h0, irq_st_reg};
            OFF_IRQ_MASK: rd_val = {29'h0, irq_mask_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // Reads have no side effects, so a lost read can simply be repeated.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arready && arvalid) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_swl_pos_code: assert property (
        (swl_pos_ev && !hm_hit) |=> err_report.code == E_SWL_POS
            && err_report.cls == CLS_1 && lw_reg[LW_SWLIM])
        else $error("positive soft limit not reported");
    a_swl_neg_code: assert property (
        (cmd_req && sw_lim_neg && !sw_lim_pos && !hm_hit)
            |=> cmd_reject && err_report.code == E_SWL_NEG)
        else $error("negative soft limit not rejected");
    a_dev_class: assert property (
        (dev_ev && !hm_hit && !swl_pos_ev && !swl_neg_ev)
            |=> err_report.code == E_DEV && lw_reg[LW_DEV]
            && err_report.cls == $past(dcls_reg))
        else $error("deviation code or class wrong");
    a_home_stop: assert property (
        (hm_hit && is_sub(hm_code)) |=> err_report.code == E_HOME
            && lw_reg[LW_HOME] && motion_stop ##1 motion_stop)
        else $error("homing error not reported");
    a_sub_range: assert property (
        $changed(sub_reg) |-> is_sub(sub_reg))
        else $error("homing sub-code out of range");
    a_lim_off: assert property (
        (hs_reg == HS_IDLE && homing_start && !multi
            && homing_mode == HM_POS_LIM && !pos_en_reg)
            |=> sub_reg == E_LIM_OFF && hs_reg == HS_HALT)
        else $error("disabled limit homing not caught");
    a_multi_sw: assert property (
        (hs_reg == HS_RUN && multi) |=> sub_reg == E_MULTI)
        else $error("multiple switches not caught");
    a_opp_pos: assert property (
        (hs_reg == HS_RUN && !multi && !homing_dir_pos && rise[SW_POS])
            |=> err_report.code == E_POS_OPP)
        else $error("opposite positive limit not caught");
    a_lw_sticky: assert property (
        !frst |=> (lw_reg & $past(lw_reg)) == $past(lw_reg))
        else $error("latched bit lost without fault reset");

    c_home_fault: cover property (hs_reg == HS_RUN ##1 hs_reg == HS_HALT);
    c_reject: cover property (cmd_reject);
    c_irq: cover property (irq ##[1:20] !irq);
    c_fault_reset: cover property (lw_reg[LW_HOME] && frst);

endmodule : hlf_top

// >>> sim/hlf_sw_model.sv
module hlf_sw_model
    import hlf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire hlf_sw_t want,
    output hlf_sw_t sw_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Plain contacts: they follow the requested level one edge later and
    // read open while the drive is held in reset, so no stale level leaks.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_pins <= '0;
        end else begin
            sw_pins <= want;
        end
    end
endmodule : hlf_sw_model

// >>> sim/hlf_top_tb.sv
module hlf_top_tb;
    import hlf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    hlf_sw_t want = '0;
    hlf_sw_t sw_pins;
    logic sw_lim_pos = 1'h0, sw_lim_neg = 1'h0, pos_dev_exceeded = 1'h0;
    logic cmd_req = 1'h0, homing_start = 1'h0;
    logic homing_dir_pos = 1'h0, homing_active = 1'h0;
    hlf_hmode_t homing_mode = HM_POS_LIM;
    logic cmd_reject, motion_stop, err_valid, irq;
    hlf_err_t err_report;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    hlf_sw_model model (.clk(clk), .rst_n(rst_n), .want(want),
        .sw_pins(sw_pins));
    hlf_top dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .sw_pins(sw_pins), .sw_lim_pos(sw_lim_pos),
        .sw_lim_neg(sw_lim_neg), .pos_dev_exceeded(pos_dev_exceeded),
        .cmd_req(cmd_req), .homing_start(homing_start),
        .homing_mode(homing_mode), .homing_dir_pos(homing_dir_pos),
        .homing_active(homing_active), .cmd_reject(cmd_reject),
        .motion_stop(motion_stop), .err_valid(err_valid),
        .err_report(err_report), .irq(irq));

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("mismatches %0d of %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'h0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'h0;
                break;
            end
        end
    endtask : axi_rd

    task automatic wait_err();
        int n;
        n = 0;
        while (err_valid !== 1'h1 && n < 80) begin
            @(posedge clk);
            n++;
        end
        chk("err_valid", {31'h0, err_valid}, 32'h1);
    endtask : wait_err

    task automatic t_regs();
        axi_rd(OFF_CTRL);
        chk("ctrl", rd, 32'h13);
        axi_rd(8'h40);
        chk("rd_resp", {30'h0, resp}, {30'h0, RESP_DECERR});
        axi_wr(8'h44, 32'h1);
        chk("wr_resp", {30'h0, resp}, {30'h0, RESP_DECERR});
    endtask : t_regs

    task automatic t_soft(input logic neg);
        logic [15:0] c;
        c = neg ? E_SWL_NEG : E_SWL_POS;
        axi_wr(OFF_IRQ_MASK, 32'h1 << IRQ_SWLIM);
        @(posedge clk);
        sw_lim_pos <= !neg;
        sw_lim_neg <= neg;
        cmd_req <= 1'h1;
        @(posedge clk);
        cmd_req <= 1'h0;
        @(posedge clk);
        chk("cmd_reject", {31'h0, cmd_reject}, 32'h1);
        chk("err", {12'h0, err_report}, {12'h0, c, CLS_1});
        chk("stop", {31'h0, motion_stop}, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        axi_rd(OFF_LATCHED);
        chk("latched", rd, 32'h1 << LW_SWLIM);
        sw_lim_pos <= 1'h0;
        sw_lim_neg <= 1'h0;
        axi_wr(OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        axi_wr(OFF_IRQ_MASK, 32'h1 << IRQ_SWLIM);
        axi_wr(OFF_IRQ_ST, 32'h1 << IRQ_SWLIM);
        repeat (2) @(posedge clk);
        chk("irq_clear", {31'h0, irq}, 32'h0);
        axi_wr(OFF_CMD, 32'h1);
        axi_rd(OFF_LATCHED);
        chk("latched_rst", rd, 32'h0);
        chk("stop_rst", {31'h0, motion_stop}, 32'h0);
        chk("err_held", {12'h0, err_report}, {12'h0, c, CLS_1});
        axi_rd(OFF_ERR);
        chk("err_reg", rd, {12'h0, c, CLS_1});
    endtask : t_soft

    task automatic t_dev();
        axi_wr(OFF_CTRL, 32'h33);
        @(posedge clk);
        pos_dev_exceeded <= 1'h1;
        wait_err();
        chk("err", {12'h0, err_report}, {12'h0, E_DEV, 4'h3});
        axi_rd(OFF_LATCHED);
        chk("latched", rd, 32'h1 << LW_DEV);
        pos_dev_exceeded <= 1'h0;
        axi_wr(OFF_CMD, 32'h1);
        axi_wr(OFF_CTRL, 32'h13);
    endtask : t_dev

    task automatic t_home(input hlf_hmode_t m, input logic d,
        input hlf_sw_t p, input hlf_sw_t r, input logic g,
        input logic [15:0] c, input logic [15:0] s);
        @(posedge clk);
        want <= p;
        homing_mode <= m;
        homing_dir_pos <= d;
        homing_active <= 1'h1;
        repeat (4) @(posedge clk);
        homing_start <= 1'h1;
        @(posedge clk);
        homing_start <= 1'h0;
        // Faults found at start pulse at once, so only runs wait here.
        // With reversal the first limit must outlast the glitch filter.
        if (r !== p) begin
            repeat (m == HM_REF_REV ? 30 : 3) @(posedge clk);
            want <= r;
        end
        if (g) begin
            repeat (5) @(posedge clk);
            want <= '0;
        end
        wait_err();
        chk("err", {12'h0, err_report}, {12'h0, c, CLS_1});
        chk("class", {28'h0, err_report.cls}, {28'h0, CLS_1});
        chk("code", {16'h0, err_report.code}, {16'h0, c});
        if (s != 16'h0) begin
            axi_rd(OFF_SUB);
            chk("sub", rd, {16'h0, s});
        end
        axi_rd(OFF_LATCHED);
        chk("latched", rd, 32'h1 << LW_HOME);
        homing_active <= 1'h0;
        want <= '0;
        repeat (4) @(posedge clk);
        axi_wr(OFF_CMD, 32'h1);
        axi_rd(OFF_LATCHED);
        chk("latched_rst", rd, 32'h0);
    endtask : t_home

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_regs();
        t_soft(1'h0);
        t_soft(1'h1);
        t_dev();
        t_home(HM_POS_LIM, 1'h1, 3'h6, 3'h6, 1'h0, E_HOME, E_MULTI);
        axi_wr(OFF_CTRL, 32'h12);
        t_home(HM_POS_LIM, 1'h1, 3'h0, 3'h0, 1'h0, E_HOME, E_LIM_OFF);
        axi_wr(OFF_CTRL, 32'h11);
        t_home(HM_NEG_LIM, 1'h0, 3'h0, 3'h0, 1'h0, E_HOME, E_LIM_OFF);
        axi_wr(OFF_CTRL, 32'h13);
        t_home(HM_REF_NOREV, 1'h1, 3'h1, 3'h1, 1'h0, E_HOME, E_ALREADY);
        t_home(HM_REF_NOREV, 1'h1, 3'h0, 3'h4, 1'h0, E_HOME, E_TRAVEL_LIM);
        t_home(HM_NEG_LIM, 1'h0, 3'h0, 3'h4, 1'h0, E_POS_OPP, 16'h0);
        t_home(HM_POS_LIM, 1'h1, 3'h0, 3'h2, 1'h0, E_NEG_OPP, 16'h0);
        t_home(HM_POS_LIM, 1'h1, 3'h0, 3'h1, 1'h1, E_REF_GL, 16'h0);
        t_home(HM_POS_LIM, 1'h1, 3'h0, 3'h4, 1'h1, E_POS_GL, 16'h0);
        t_home(HM_NEG_LIM, 1'h0, 3'h0, 3'h2, 1'h1, E_NEG_GL, 16'h0);
        t_home(HM_REF_REV, 1'h0, 3'h4, 3'h2, 1'h0, E_HOME, E_NO_REF);
        t_home(HM_POS_LIM, 1'h1, 3'h0, 3'h6, 1'h0, E_HOME, E_MULTI);
        report_and_stop();
    end
endmodule : hlf_top_tb
